// File: rtl/bus_voltage_supervisor.v
// bus voltage supervisor with group fault propagation and axi4-lite
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bus_supervisor_defines.vh"
module bus_voltage_supervisor #(
  parameter GROUPS = 4,
  parameter AUX = 4,
  parameter CONVS = 32,
  parameter ESC_CYC = `T_ESCALATE_MS * `CYC_MS,
  parameter CROWBAR_CYC = `T_CROWBAR_MS * `CYC_MS,
  parameter RESTART_CYC = `T_RESTART_MS * `CYC_MS,
  parameter FILTER_CYC = `T_FILTER_US * `CYC_US,
  parameter SECOND_CYC = `T_SECOND_MS * `CYC_MS
) (
  // clock and reset
  input wire CLK_IN,
  input wire RSTN_IN,
  // converter samples
  input wire [9:0] SAMPLE_DATA_IN,
  input wire SAMPLE_VALID_IN,
  output reg REF_EXTERNAL_OUT,
  // group health lines, open drain
  input wire [GROUPS-1:0] HEALTH_IN,
  output reg [GROUPS-1:0] HEALTH_OUT,
  output reg [GROUPS-1:0] HEALTH_OE_OUT,
  input wire [GROUPS-1:0] ERROR_IN,
  // auxiliary devices
  output reg [AUX-1:0] AUX_FAULT_OUT,
  // front end and crowbar
  output reg FRONT_END_ENABLE_OUT,
  output reg CROWBAR_TRIGGER_OUT,
  // programming engine handshake
  output reg PROG_START_OUT,
  input wire PROG_DONE_IN,
  input wire [CONVS-1:0] PROG_ACK_OK_IN,
  input wire [CONVS-1:0] PROG_READ_OK_IN,
  output reg CONV_TURN_ON_OUT,
  // run-time save to non-volatile store
  output reg RUNTIME_SAVE_OUT,
  output reg [31:0] RUNTIME_OUT,
  // axi4-lite slave
  input wire [11:0] AWADDR_IN,
  input wire AWVALID_IN,
  output reg AWREADY_OUT,
  input wire [31:0] WDATA_IN,
  input wire [3:0] WSTRB_IN,
  input wire WVALID_IN,
  output reg WREADY_OUT,
  output reg [1:0] BRESP_OUT,
  output reg BVALID_OUT,
  input wire BREADY_IN,
  input wire [11:0] ARADDR_IN,
  input wire ARVALID_IN,
  output reg ARREADY_OUT,
  output reg [31:0] RDATA_OUT,
  output reg [1:0] RRESP_OUT,
  output reg RVALID_OUT,
  input wire RREADY_IN
);

  localparam ST_RUN = 2'd0;
  localparam ST_UNDER = 2'd1;
  localparam ST_OVER = 2'd2;
  localparam ST_WAIT = 2'd3;
  localparam OV_SHED = 2'd0;
  localparam OV_FE_OFF = 2'd1;
  localparam OV_CROWBAR = 2'd2;
  localparam OV_DONE = 2'd3;

  // pin synchronisers
  reg [GROUPS-1:0] health_s1_r, health_s2_r;
  reg [GROUPS-1:0] error_s1_r, error_s2_r;
  reg [CONVS-1:0] ack_s1_r, ack_s2_r, rd_s1_r, rd_s2_r;
  reg done_s1_r, done_s2_r;

  reg [9:0] sample_r, low_th_r, high_th_r, hyst_r;
  reg [31:0] ctrl_r, prop_r, runtime_r, prog_bits_r;
  reg low_raw_r, high_raw_r, low_flag_r, high_flag_r;
  reg low_status_r, high_status_r;
  reg [31:0] low_filt_r, high_filt_r;
  reg [1:0] state_r, ov_r;
  reg [31:0] timer_r, sec_r;
  reg prog_busy_r, prog_req_r, on_pending_r;
  reg aw_seen_r, w_seen_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  // saturating subtract / add keep the band inside the code range
  function [9:0] sub_sat;
    input [9:0] a;
    input [9:0] b;
    begin
      sub_sat = (a > b) ? a - b : 10'h000;
    end
  endfunction
  function [9:0] add_sat;
    input [9:0] a;
    input [9:0] b;
    reg [10:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      add_sat = s[10] ? 10'h3ff : s[9:0];
    end
  endfunction

  // merge a write with its byte strobes
  function [31:0] strobe;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer i;
    begin
      strobe = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (s[i])
          strobe[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  wire [9:0] low_below = sub_sat(low_th_r, hyst_r);
  wire [9:0] low_above = add_sat(low_th_r, hyst_r);
  wire [9:0] high_below = sub_sat(high_th_r, hyst_r);
  wire [9:0] high_above = add_sat(high_th_r, hyst_r);
  wire [31:0] low_th_wr = strobe({22'h0, low_th_r}, wdata_r, wstrb_r);
  wire [31:0] high_th_wr = strobe({22'h0, high_th_r}, wdata_r, wstrb_r);
  wire [31:0] hyst_wr = strobe({22'h0, hyst_r}, wdata_r, wstrb_r);

  // group propagation: prop_r[4*src+dst] lets source group pull dest
  reg [GROUPS-1:0] prop_drive;
  reg any_error;
  integer g, d;
  always @* begin
    prop_drive = {GROUPS{1'b0}};
    any_error = 1'b0;
    for (g = 0; g < GROUPS; g = g + 1) begin
      for (d = 0; d < GROUPS; d = d + 1) begin
        if (!health_s2_r[g] && prop_r[4*g+d] && g != d)
          prop_drive[d] = 1'b1;
      end
      if (!health_s2_r[g] && error_s2_r[g])
        any_error = 1'b1;
    end
  end
  wire shed_all = (state_r != ST_RUN);
  wire [GROUPS-1:0] pull_low = prop_drive | {GROUPS{shed_all}};

  wire aw_take = AWVALID_IN && AWREADY_OUT;
  wire w_take = WVALID_IN && WREADY_OUT;
  wire do_write = aw_seen_r && w_seen_r && !BVALID_OUT;
  wire write_ctrl = do_write && awaddr_r == `REG_CTRL;
  wire host_on = write_ctrl && wstrb_r[0] && wdata_r[`CTRL_TURN_ON];
  // only the run state saves, so a low seen while waiting cannot repeat it
  wire runtime_save = (low_flag_r && !low_status_r && state_r == ST_RUN) ||
    (high_flag_r && !high_status_r && state_r == ST_RUN);

  always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      health_s1_r <= {GROUPS{1'b1}};
      health_s2_r <= {GROUPS{1'b1}};
      error_s1_r <= {GROUPS{1'b0}};
      error_s2_r <= {GROUPS{1'b0}};
      ack_s1_r <= {CONVS{1'b0}};
      ack_s2_r <= {CONVS{1'b0}};
      rd_s1_r <= {CONVS{1'b0}};
      rd_s2_r <= {CONVS{1'b0}};
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      sample_r <= 10'h000;
      low_th_r <= `LOW_TH_RST;
      high_th_r <= `HIGH_TH_RST;
      hyst_r <= `HYST_RST;
      ctrl_r <= 32'h0000_0000;
      prop_r <= `PROP_RST;
      runtime_r <= 32'h0000_0000;
      sec_r <= 32'h0000_0000;
      prog_bits_r <= 32'h0000_0000;
      low_raw_r <= 1'b1;
      high_raw_r <= 1'b0;
      low_flag_r <= 1'b1;
      high_flag_r <= 1'b0;
      low_status_r <= 1'b1;
      high_status_r <= 1'b0;
      low_filt_r <= 32'h0000_0000;
      high_filt_r <= 32'h0000_0000;
      state_r <= ST_UNDER;
      ov_r <= OV_SHED;
      timer_r <= 32'h0000_0000;
      prog_busy_r <= 1'b0;
      prog_req_r <= 1'b0;
      on_pending_r <= 1'b0;
      HEALTH_OUT <= {GROUPS{1'b0}};
      HEALTH_OE_OUT <= {GROUPS{1'b0}};
      AUX_FAULT_OUT <= {AUX{1'b0}};
      FRONT_END_ENABLE_OUT <= 1'b1;
      CROWBAR_TRIGGER_OUT <= 1'b0;
      REF_EXTERNAL_OUT <= 1'b0;
      PROG_START_OUT <= 1'b0;
      CONV_TURN_ON_OUT <= 1'b0;
      RUNTIME_SAVE_OUT <= 1'b0;
      RUNTIME_OUT <= 32'h0000_0000;
      aw_seen_r <= 1'b0;
      w_seen_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT <= 1'b0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= 2'b00;
      ARREADY_OUT <= 1'b0;
      RVALID_OUT <= 1'b0;
      RRESP_OUT <= 2'b00;
      RDATA_OUT <= 32'h0000_0000;
    end else begin
      health_s1_r <= HEALTH_IN;
      health_s2_r <= health_s1_r;
      error_s1_r <= ERROR_IN;
      error_s2_r <= error_s1_r;
      ack_s1_r <= PROG_ACK_OK_IN;
      ack_s2_r <= ack_s1_r;
      rd_s1_r <= PROG_READ_OK_IN;
      rd_s2_r <= rd_s1_r;
      done_s1_r <= PROG_DONE_IN;
      done_s2_r <= done_s1_r;

      if (SAMPLE_VALID_IN) begin
        sample_r <= SAMPLE_DATA_IN;
        // raw latched levels move only at band edges
        if (SAMPLE_DATA_IN < low_below)
          low_raw_r <= 1'b1;
        else if (SAMPLE_DATA_IN > low_above)
          low_raw_r <= 1'b0;
        if (SAMPLE_DATA_IN > high_above)
          high_raw_r <= 1'b1;
        else if (SAMPLE_DATA_IN < high_below)
          high_raw_r <= 1'b0;
      end

      // ~1ms qualification filters against single-sample glitches
      if (low_raw_r == low_flag_r)
        low_filt_r <= 32'h0000_0000;
      else if (low_filt_r >= FILTER_CYC - 1) begin
        low_flag_r <= low_raw_r;
        low_filt_r <= 32'h0000_0000;
      end else
        low_filt_r <= low_filt_r + 32'h1;
      if (high_raw_r == high_flag_r)
        high_filt_r <= 32'h0000_0000;
      else if (high_filt_r >= FILTER_CYC - 1) begin
        high_flag_r <= high_raw_r;
        high_filt_r <= 32'h0000_0000;
      end else
        high_filt_r <= high_filt_r + 32'h1;

      // run-time counter, one tick per second
      if (sec_r >= SECOND_CYC - 1) begin
        sec_r <= 32'h0000_0000;
        runtime_r <= runtime_r + 32'h1;
      end else
        sec_r <= sec_r + 32'h1;
      RUNTIME_SAVE_OUT <= runtime_save;
      if (runtime_save)
        RUNTIME_OUT <= runtime_r;

      // programming bits need both ack and readback
      PROG_START_OUT <= prog_req_r;
      prog_req_r <= 1'b0;
      if (prog_busy_r)
        prog_bits_r <= prog_bits_r | (ack_s2_r & rd_s2_r);
      CONV_TURN_ON_OUT <= 1'b0;
      if (prog_busy_r && done_s2_r) begin
        prog_busy_r <= 1'b0;
        if (ctrl_r[`CTRL_AUTO_ON])
          CONV_TURN_ON_OUT <= 1'b1;
        else
          on_pending_r <= 1'b1;
      end
      if (on_pending_r && host_on && state_r == ST_RUN) begin
        on_pending_r <= 1'b0;
        CONV_TURN_ON_OUT <= 1'b1;
      end
      CROWBAR_TRIGGER_OUT <= 1'b0;

      case (state_r)
        ST_RUN: begin
          if (low_flag_r) begin
            state_r <= ST_UNDER;
            prog_bits_r <= 32'h0000_0000;
            prog_busy_r <= 1'b0;
            on_pending_r <= 1'b0;
          end else if (high_flag_r) begin
            state_r <= ST_OVER;
            ov_r <= OV_SHED;
            timer_r <= 32'h0000_0000;
          end
        end
        ST_UNDER: begin
          low_status_r <= 1'b1;
          prog_bits_r <= 32'h0000_0000;
          if (!low_flag_r && !high_flag_r) begin
            low_status_r <= 1'b0;
            state_r <= ST_RUN;
            prog_req_r <= 1'b1;
            prog_busy_r <= 1'b1;
          end
        end
        ST_OVER: begin
          if (!high_flag_r) begin
            state_r <= ST_WAIT;
            timer_r <= 32'h0000_0000;
            CROWBAR_TRIGGER_OUT <= 1'b0;
          end else begin
            timer_r <= timer_r + 32'h1;
            case (ov_r)
              OV_SHED: if (timer_r >= ESC_CYC - 1) begin
                FRONT_END_ENABLE_OUT <= 1'b0;
                prog_bits_r <= 32'h0000_0000;
                high_status_r <= 1'b1;
                ov_r <= OV_FE_OFF;
                timer_r <= 32'h0000_0000;
              end
              OV_FE_OFF: if (timer_r >= ESC_CYC - 1) begin
                ov_r <= OV_CROWBAR;
                timer_r <= 32'h0000_0000;
              end
              OV_CROWBAR: begin
                CROWBAR_TRIGGER_OUT <= 1'b1;
                // timer starts at zero here, so cut after the full width
                if (timer_r >= CROWBAR_CYC) begin
                  CROWBAR_TRIGGER_OUT <= 1'b0;
                  ov_r <= OV_DONE;
                end
              end
              default: timer_r <= timer_r;
            endcase
          end
        end
        ST_WAIT: begin
          if (high_flag_r) begin
            state_r <= ST_OVER;
            timer_r <= 32'h0000_0000;
          end else if (timer_r >= RESTART_CYC - 1) begin
            FRONT_END_ENABLE_OUT <= 1'b1;
            high_status_r <= 1'b0;
            state_r <= low_flag_r ? ST_UNDER : ST_RUN;
            prog_req_r <= !low_flag_r;
            prog_busy_r <= !low_flag_r;
            prog_bits_r <= 32'h0000_0000;
          end else
            timer_r <= timer_r + 32'h1;
        end
        default: state_r <= ST_UNDER;
      endcase

      // group errors drop the front end and fire the crowbar
      if (any_error && state_r == ST_RUN) begin
        FRONT_END_ENABLE_OUT <= 1'b0;
        CROWBAR_TRIGGER_OUT <= 1'b1;
      end

      // open drain: only ever drive low, three cycles from pin
      HEALTH_OUT <= {GROUPS{1'b0}};
      HEALTH_OE_OUT <= pull_low;
      // aux fed from converter groups only, never the reverse
      AUX_FAULT_OUT <= {AUX{|(~health_s2_r)}} &
        ~ctrl_r[`CTRL_AUX_DIS_LSB +: AUX];
      REF_EXTERNAL_OUT <= ctrl_r[`CTRL_EXT_REF];

      // axi4-lite write
      AWREADY_OUT <= !aw_seen_r && !AWREADY_OUT && AWVALID_IN;
      WREADY_OUT <= !w_seen_r && !WREADY_OUT && WVALID_IN;
      if (aw_take) begin
        aw_seen_r <= 1'b1;
        awaddr_r <= AWADDR_IN;
      end
      if (w_take) begin
        w_seen_r <= 1'b1;
        wdata_r <= WDATA_IN;
        wstrb_r <= WSTRB_IN;
      end
      if (do_write) begin
        aw_seen_r <= 1'b0;
        w_seen_r <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= 2'b00;
        case (awaddr_r)
          `REG_CTRL: ctrl_r <= strobe(ctrl_r, wdata_r, wstrb_r) &
            ~(32'h1 << `CTRL_TURN_ON);
          `REG_LOW_TH: low_th_r <= low_th_wr[9:0];
          `REG_HIGH_TH: high_th_r <= high_th_wr[9:0];
          `REG_HYST: hyst_r <= hyst_wr[9:0];
          `REG_PROP: prop_r <= strobe(prop_r, wdata_r, wstrb_r);
          `REG_STATUS, `REG_SAMPLE, `REG_RUNTIME, `REG_PROG:
            BRESP_OUT <= 2'b00;
          default: BRESP_OUT <= 2'b10;
        endcase
      end else if (BVALID_OUT && BREADY_IN)
        BVALID_OUT <= 1'b0;

      // axi4-lite read
      ARREADY_OUT <= !ARREADY_OUT && !RVALID_OUT && ARVALID_IN;
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RRESP_OUT <= 2'b00;
        case (ARADDR_IN)
          `REG_CTRL: RDATA_OUT <= ctrl_r;
          `REG_LOW_TH: RDATA_OUT <= {22'h0, low_th_r};
          `REG_HIGH_TH: RDATA_OUT <= {22'h0, high_th_r};
          `REG_HYST: RDATA_OUT <= {22'h0, hyst_r};
          `REG_PROP: RDATA_OUT <= prop_r;
          `REG_STATUS: RDATA_OUT <= {26'h0, on_pending_r ? 1'b0 : 1'b0,
            prog_busy_r, state_r == ST_RUN, FRONT_END_ENABLE_OUT,
            high_status_r, low_status_r};
          `REG_SAMPLE: RDATA_OUT <= {22'h0, sample_r};
          `REG_RUNTIME: RDATA_OUT <= runtime_r;
          `REG_PROG: RDATA_OUT <= prog_bits_r;
          default: begin
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= 2'b10;
          end
        endcase
      end else if (RVALID_OUT && RREADY_IN)
        RVALID_OUT <= 1'b0;
    end
  end

endmodule // bus_voltage_supervisor

// File: rtl/bus_supervisor_defines.vh
// constants and register map of the bus voltage supervisor
// What this block does
// - sample bus voltage, keep latest 10-bit result
// - compare samples with low and high thresholds
// - programmable symmetric hysteresis around both thresholds
// - undervoltage pulls all group health lines low
// - undervoltage clears programmed bits, saves run-time
// - undervoltage sets bus-low status flag
// - low recovery reprograms, then auto turn-on
// - overvoltage pulls health lines low, saves run-time
// - overvoltage 50ms: drop front-end, flag bus-high
// - further 50ms: crowbar pulse for 1ms
// - one second after recovery: front-end, reprogram
// - threshold crossing to health lines about 1ms
// - configuration selects internal or external reference
// - up to four groups of converters
// - propagate between groups; errors hit front-end, crowbar
// - propagation under 10us
// - per auxiliary device fault propagation disable
// - auxiliary faults never reach converters
// - low group line pulls enabled other groups low
// - programmed bit set after ack and readback pass
// - four-byte run-time counter, once per second
`ifndef BUS_SUPERVISOR_DEFINES_VH
`define BUS_SUPERVISOR_DEFINES_VH

`define CLK_HZ 40000000
`define T_ESCALATE_MS 50
`define T_CROWBAR_MS 1
`define T_RESTART_MS 1000
`define T_FILTER_US 1000
`define T_SECOND_MS 1000
`define CYC_MS (`CLK_HZ / 1000)
`define CYC_US (`CLK_HZ / 1000000)

// register byte offsets
`define REG_CTRL 12'h000
`define REG_LOW_TH 12'h004
`define REG_HIGH_TH 12'h008
`define REG_HYST 12'h00c
`define REG_PROP 12'h010
`define REG_STATUS 12'h014
`define REG_SAMPLE 12'h018
`define REG_RUNTIME 12'h01c
`define REG_PROG 12'h020

// control fields
`define CTRL_AUTO_ON 0
`define CTRL_EXT_REF 1
`define CTRL_TURN_ON 2
`define CTRL_AUX_DIS_LSB 4

// reset values
`define LOW_TH_RST 10'h200
`define HIGH_TH_RST 10'h300
`define HYST_RST 10'h010
`define PROP_RST 32'h0000_0000

// status fields
`define ST_LOW 0
`define ST_HIGH 1
`define ST_FE 2
`define ST_ON 3
`define ST_PROG_BUSY 4
`define ST_SAVE 5

`endif

// File: verification/bus_supervisor_monitor.sv
// assertion checker on the supervisor ports
`timescale 1ns/1ps
module bus_supervisor_monitor #(
  parameter GROUPS = 4,
  parameter CROWBAR_CYC = 40000
) (
  // clock and reset
  input wire CLK_IN,
  input wire RSTN_IN,
  // health lines
  input wire [GROUPS-1:0] HEALTH_OUT,
  input wire [GROUPS-1:0] HEALTH_OE_OUT,
  // power path
  input wire FRONT_END_ENABLE_OUT,
  input wire CROWBAR_TRIGGER_OUT,
  // sequencing pulses
  input wire PROG_START_OUT,
  input wire CONV_TURN_ON_OUT,
  input wire RUNTIME_SAVE_OUT
);
  logic [31:0] cb_run_r;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  always @(posedge CLK_IN) begin
    if (!RSTN_IN || !CROWBAR_TRIGGER_OUT)
      cb_run_r <= 32'h0;
    else
      cb_run_r <= cb_run_r + 32'h1;
  end
  chk_health_od: assert property (HEALTH_OUT == {GROUPS{1'b0}})
    else $error("health line driven high");
  chk_crowbar_fe: assert property (
    CROWBAR_TRIGGER_OUT |-> !FRONT_END_ENABLE_OUT)
    else $error("crowbar with front end on");
  chk_crowbar_len: assert property (
    $fell(CROWBAR_TRIGGER_OUT) |-> cb_run_r == CROWBAR_CYC)
    else $error("crowbar pulse width wrong");
  chk_fe_drop_oe: assert property ($fell(FRONT_END_ENABLE_OUT) &&
    !CROWBAR_TRIGGER_OUT |-> &HEALTH_OE_OUT)
    else $error("front end dropped with lines released");
  chk_fe_restart: assert property (
    $rose(FRONT_END_ENABLE_OUT) |-> ##[0:2] PROG_START_OUT)
    else $error("no programming after front end return");
  chk_prog_pulse: assert property (
    PROG_START_OUT |=> !PROG_START_OUT)
    else $error("programming start not a pulse");
  chk_turn_on: assert property (
    CONV_TURN_ON_OUT |=> !CONV_TURN_ON_OUT)
    else $error("turn-on not a pulse");
  chk_save_pulse: assert property (
    RUNTIME_SAVE_OUT |=> !RUNTIME_SAVE_OUT)
    else $error("run-time save not a pulse");
endmodule // bus_supervisor_monitor

bind bus_voltage_supervisor bus_supervisor_monitor #(
  .GROUPS(GROUPS), .CROWBAR_CYC(CROWBAR_CYC)) bus_supervisor_monitor_i (
  .CLK_IN, .RSTN_IN, .HEALTH_OUT, .HEALTH_OE_OUT, .FRONT_END_ENABLE_OUT,
  .CROWBAR_TRIGGER_OUT, .PROG_START_OUT, .CONV_TURN_ON_OUT,
  .RUNTIME_SAVE_OUT);

// File: verification/pol_group_model.sv
// converter groups and programming engine model
`timescale 1ns/1ps
module pol_group_model (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // from the supervisor and bench
  input wire [3:0] oe_in,
  input wire [3:0] fault_in,
  input wire prog_start_in,
  // towards the supervisor
  output wire [3:0] health_out,
  output wire prog_done_out,
  output wire [31:0] ack_ok_out,
  output wire [31:0] read_ok_out
);
  logic [5:0] cnt_r;
  // pulled-up wire: low if any party pulls
  assign health_out = ~(oe_in | fault_in);
  assign ack_ok_out = 32'hffffffff;
  assign read_ok_out = 32'hffffffff;
  // done held for several cycles so the sync flops catch it
  assign prog_done_out = (cnt_r >= 6'd25);
  always @(posedge clk_in) begin
    if (!rstn_in)
      cnt_r <= 6'h0;
    else if (prog_start_in)
      cnt_r <= 6'h1;
    else if (cnt_r != 6'h0)
      cnt_r <= (cnt_r == 6'd30) ? 6'h0 : cnt_r + 6'h1;
  end
endmodule // pol_group_model

// File: verification/bus_voltage_supervisor_tb_top.sv
// self-checking bench for the bus voltage supervisor
`timescale 1ns/1ps
`include "bus_supervisor_defines.vh"
module bus_voltage_supervisor_tb_top;
  localparam int ESC = 200, CBW = 20, RST_C = 300, FLT = 10;
  logic clk, rstn, awv, wv, bready, arv, rready;
  logic awready, wready, bvalid, arready, rvalid, fe, cb, ps, pd, ton, sv;
  logic ref_ext, s;
  logic [9:0] smp;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ack, rok, rt, r;
  logic [3:0] oe, hout, health, aux, fault, err;
  logic [1:0] bresp, rresp;
  logic [33:0] qv[$], qm[$];
  int bad_count, n_tests, saves, s0, k;

  bus_voltage_supervisor #(.ESC_CYC(ESC), .CROWBAR_CYC(CBW),
    .RESTART_CYC(RST_C), .FILTER_CYC(FLT), .SECOND_CYC(50))
  bus_voltage_supervisor_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .SAMPLE_DATA_IN(smp), .SAMPLE_VALID_IN(sv), .REF_EXTERNAL_OUT(ref_ext),
    .HEALTH_IN(health), .HEALTH_OUT(hout), .HEALTH_OE_OUT(oe),
    .ERROR_IN(err), .AUX_FAULT_OUT(aux), .FRONT_END_ENABLE_OUT(fe),
    .CROWBAR_TRIGGER_OUT(cb), .PROG_START_OUT(ps), .PROG_DONE_IN(pd),
    .PROG_ACK_OK_IN(ack), .PROG_READ_OK_IN(rok), .CONV_TURN_ON_OUT(ton),
    .RUNTIME_SAVE_OUT(s), .RUNTIME_OUT(rt), .AWADDR_IN(awaddr),
    .AWVALID_IN(awv), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arv), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready));
  pol_group_model pol_group_model_i (.clk_in(clk), .rstn_in(rstn),
    .oe_in(oe), .fault_in(fault), .prog_start_in(ps), .health_out(health),
    .prog_done_out(pd), .ack_ok_out(ack), .read_ok_out(rok));

  task cmp(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chkq(input logic [33:0] g);
    cmp(g & qm[0], qv[0] & qm[0]);
    void'(qv.pop_front());
    void'(qm.pop_front());
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] rs);
    qv.push_back({rs, 32'h0});
    qm.push_back({2'h3, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m, input [1:0] rs);
    qv.push_back({rs, e});
    qm.push_back({2'h3, m});
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task print_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // results are taken off the note queue as they appear
  always @(posedge clk) begin
    if (rvalid && rready) chkq({rresp, rdata});
    if (bvalid && bready) chkq({bresp, 32'h0});
    if (s === 1'b1) saves++;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  initial begin
    {rstn, awv, wv, bready, arv, rready, fault, err} = '0;
    {awaddr, araddr, wdata} = '0;
    smp = 10'h100;
    sv = 1'b1;
    void'($urandom(32'h2405));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(`REG_LOW_TH, 32'(`LOW_TH_RST), 32'h3ff, 2'h0);
    rd(`REG_HIGH_TH, 32'(`HIGH_TH_RST), 32'h3ff, 2'h0);
    rd(`REG_HYST, 32'(`HYST_RST), 32'h3ff, 2'h0);
    rd(`REG_STATUS, 32'h5, 32'h7, 2'h0);
    rd(12'h100, 32'h0, 32'hffffffff, 2'h2);
    wr(12'h100, 32'h1, 2'h2);
    r = $urandom;
    wr(`REG_PROP, r, 2'h0);
    rd(`REG_PROP, r, 32'hffff, 2'h0);
    wr(`REG_PROP, 32'h2, 2'h0);
    wr(`REG_CTRL, 32'h1, 2'h0);
    smp <= 10'h211 + 10'($urandom % 200);
    repeat (FLT + 80) @(posedge clk);
    rd(`REG_STATUS, 32'h4, 32'h7, 2'h0);
    rd(`REG_PROG, 32'hffffffff, 32'hffffffff, 2'h0);
    cmp(34'(oe), 34'h0);
    fault <= 4'h1;
    repeat (10) @(posedge clk);
    cmp(34'(oe), 34'h2);
    cmp(34'(aux), 34'hf);
    wr(`REG_CTRL, 32'h53, 2'h0);
    repeat (5) @(posedge clk);
    cmp(34'(aux), 34'ha);
    cmp(34'(ref_ext), 34'h1);
    fault <= 4'h0;
    repeat (10) @(posedge clk);
    cmp(34'(oe), 34'h0);
    smp <= 10'h305;
    repeat (FLT + 20) @(posedge clk);
    cmp(34'(oe), 34'h0);
    rd(`REG_SAMPLE, 32'h305, 32'h3ff, 2'h0);
    s0 = saves;
    smp <= 10'h320;
    repeat (FLT + 5) @(posedge clk);
    cmp(34'(oe), 34'hf);
    cmp(34'(saves - s0), 34'h1);
    smp <= 10'h250;
    repeat (ESC + 20) @(posedge clk);
    cmp(34'(fe), 34'h1);
    repeat (RST_C + 80) @(posedge clk);
    smp <= 10'h320;
    repeat (FLT + ESC + 10) @(posedge clk);
    rd(`REG_STATUS, 32'h2, 32'h6, 2'h0);
    rd(`REG_PROG, 32'h0, 32'hffffffff, 2'h0);
    k = 0;
    while (!cb && k < 1000) begin
      @(negedge clk);
      k++;
    end
    cmp(34'(fe), 34'h0);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cb && k < 1000);
    cmp(34'(k), 34'(CBW));
    @(posedge clk);
    smp <= 10'h250;
    repeat (RST_C + FLT + 10) @(posedge clk);
    cmp(34'(fe), 34'h1);
    rd(`REG_PROG, 32'hffffffff, 32'hffffffff, 2'h0);
    // error held one crowbar width, so the pulse keeps its length
    fault <= 4'h1;
    err <= 4'h1;
    repeat (4) @(posedge clk);
    cmp(34'(cb), 34'h1);
    cmp(34'(fe), 34'h0);
    repeat (CBW - 4) @(posedge clk);
    {fault, err} <= '0;
    s0 = saves;
    smp <= 10'h100;
    repeat (FLT + 10) @(posedge clk);
    cmp(34'(oe), 34'hf);
    rd(`REG_STATUS, 32'h1, 32'h1, 2'h0);
    rd(`REG_PROG, 32'h0, 32'hffffffff, 2'h0);
    cmp(34'(saves - s0), 34'h1);
    cmp(34'(rt != 32'h0), 34'h1);
    print_verdict;
  end
endmodule // bus_voltage_supervisor_tb_top
